// ### tb.sv
// Self-checking bench: AHB-Lite master, serial partner, queue-fed scoreboard.
// Assumes DL=1 and DIV=2, giving one 16x tick per core clock.
`timescale 1ns/1ns
module tb import ufc_pkg::*;;
  logic CORE_CLK, RST_N, HSEL, HWRITE, CTS_N, DSR_N, pe, rx_val;
  logic [31:0] HADDR, HWDATA, HRDATA, d;
  logic [1:0] HTRANS;
  logic HREADYOUT, HRESP, TXD, RXD, DTR_N, RTS_N;
  logic [3:0] nb;
  logic [8:0] rx_word;
  logic [7:0] b;
  logic [8:0] expq[$];
  int fail_count, tests_run, i, seed;
  ufc_uart dut_u (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP), .TXD(TXD), .RXD(RXD), .CTS_N(CTS_N), .DSR_N(DSR_N),
    .RI_N(1'b1), .DCD_N(1'b1), .DTR_N(DTR_N), .RTS_N(RTS_N));
  ufc_remote rem_u (.clk(CORE_CLK), .txd(TXD), .nbits(nb), .par_en(pe), .rxd(RXD), .rx_val(rx_val),
    .rx_word(rx_word));
  // Clock, 4 ns period
  initial begin
    CORE_CLK = 1'b0;
    forever #2 CORE_CLK = ~CORE_CLK;
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // Bounded wait for HREADY high at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge CORE_CLK);
      n++;
    end while (HREADYOUT !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      conclude();
    end
  endtask : wait_rdy
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CORE_CLK);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR <= {24'h000000, a};
    wait_rdy();
    HTRANS <= 2'h0;
    HSEL <= 1'b0;
    HWDATA <= wd;
    wait_rdy();
    rd = HRDATA;
  endtask : bus
  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(1'b1, a, wd, x);
  endtask : wr
  // Bounded wait until every queued character has come out of TXD
  task automatic drain();
    int n;
    for (n = 0; n < 3000 && expq.size() != 0; n++) @(posedge CORE_CLK);
    if (expq.size() != 0) chk("drain", 32'h1, 32'h0);
    repeat (8) @(posedge CORE_CLK);
  endtask : drain
  // Scoreboard: oldest note against each character seen on the line
  always @(posedge CORE_CLK) begin
    if (rx_val === 1'b1) begin
      if (expq.size() == 0) chk("serial_extra", 32'h1, 32'h0);
      else chk("serial_char", 32'(rx_word), 32'(expq.pop_front()));
    end
  end
  initial begin
    seed = $urandom(32'h4aa5);
    {RST_N, HSEL, HWRITE, HADDR, HWDATA, HTRANS, CTS_N, DSR_N, pe} = '0;
    DSR_N = 1'b1;
    nb = 4'h8;
    repeat (4) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge CORE_CLK);
    chk("idle_lines", {HRESP, TXD, RTS_N, DTR_N}, 32'h7);
    bus(1'b0, UFC_A_LSR, 0, d);
    chk("lsr_idle", d[6:5], 32'h3);
    // CTS held active from reset leaves a change flag; read it out so later identity checks start clean
    bus(1'b0, UFC_A_MSR, 0, d);
    chk("msr_init", d[4:0], 32'h11);
    wr(UFC_A_DL, 32'h1);
    wr(UFC_A_DIV, 32'h2);
    wr(UFC_A_FCR, 32'h81);
    $display("test reset done");
    // Each word length with one parity mode: 5 odd, 6 even, 7 mark, 8 space
    for (i = 0; i < 4; i++) begin
      nb <= 4'(5 + i);
      pe <= 1'b1;
      b = 8'($urandom) & 8'((1 << (5 + i)) - 1);
      expq.push_back({(i == 0) ? ~^b : (i == 1) ? ^b : (i == 2), b});
      wr(UFC_A_LCR, 32'(i | 8 | (i << 4) | ((i & 1) << 2)));
      wr(UFC_A_DATA, 32'(b));
      drain();
    end
    $display("test format done");
    // Ten writes: one to the shifter, eight queued, the last refused
    nb <= 4'h8;
    pe <= 1'b0;
    wr(UFC_A_LCR, 32'h3);
    for (i = 0; i < 10; i++) begin
      b = 8'($urandom);
      if (i < 9) expq.push_back({1'b0, b});
      wr(UFC_A_DATA, 32'(b));
    end
    bus(1'b0, UFC_A_TFC, 0, d);
    chk("tfc_full", d, 32'h8);
    bus(1'b0, UFC_A_LSR, 0, d);
    chk("lsr_busy", d[6:5], 32'h0);
    drain();
    bus(1'b0, UFC_A_LSR, 0, d);
    chk("lsr_done", d[6:5], 32'h3);
    bus(1'b0, UFC_A_IIR, 0, d);
    chk("iir_thre", d, {24'h0, 4'hC, UFC_IIR_THRE});
    bus(1'b0, UFC_A_IIR, 0, d);
    chk("iir_clr", d, {24'h0, 4'hC, UFC_IIR_NONE});
    $display("test burst done");
    // Reception up to trigger 4 with auto RTS
    wr(UFC_A_MCR, 32'h22);
    // RTS_N is registered from the new control value, so let it settle
    repeat (2) @(posedge CORE_CLK);
    chk("rts_on", RTS_N, 32'h0);
    for (i = 0; i < 4; i++) rem_u.send(8'(8'hA0 + 8'(i)));
    repeat (4) @(posedge CORE_CLK);
    chk("rts_off", RTS_N, 32'h1);
    bus(1'b0, UFC_A_RFC, 0, d);
    chk("rfc", d, 32'h4);
    bus(1'b0, UFC_A_IIR, 0, d);
    chk("iir_rda", d[3:0], 32'(UFC_IIR_RDA));
    for (i = 0; i < 4; i++) begin
      bus(1'b0, UFC_A_LSR, 0, d);
      chk("dr_set", d[0], 32'h1);
      bus(1'b0, UFC_A_DATA, 0, d);
      chk("rx_data", d, 32'(8'hA0 + 8'(i)));
    end
    repeat (2) @(posedge CORE_CLK);
    chk("rts_back", RTS_N, 32'h0);
    bus(1'b0, UFC_A_LSR, 0, d);
    chk("dr_clr", d[0], 32'h0);
    $display("test receive done");
    // One byte left alone: no event early, timeout after 4 characters
    rem_u.send(8'h5A);
    repeat (500) @(posedge CORE_CLK);
    bus(1'b0, UFC_A_IIR, 0, d);
    chk("tout_early", d[3:0], 32'(UFC_IIR_NONE));
    repeat (200) @(posedge CORE_CLK);
    bus(1'b0, UFC_A_IIR, 0, d);
    chk("tout", d[3:0], 32'(UFC_IIR_TOUT));
    bus(1'b0, UFC_A_DATA, 0, d);
    bus(1'b0, UFC_A_IIR, 0, d);
    chk("tout_clr", d[3:0], 32'(UFC_IIR_NONE));
    $display("test timeout done");
    // Auto CTS holds the character; CTS going active again leaves no change flag
    wr(UFC_A_MCR, 32'h21);
    // CTS must be seen inactive through the synchroniser before the byte is queued
    CTS_N <= 1'b1;
    repeat (8) @(posedge CORE_CLK);
    chk("dtr", DTR_N, 32'h0);
    bus(1'b0, UFC_A_MSR, 0, d);
    expq.push_back(9'h03C);
    wr(UFC_A_DATA, 32'h3C);
    repeat (300) @(posedge CORE_CLK);
    chk("cts_hold", expq.size(), 32'h1);
    bus(1'b0, UFC_A_MSR, 0, d);
    chk("msr_cts_off", d[4:0], 32'h0);
    CTS_N <= 1'b0;
    DSR_N <= 1'b0;
    drain();
    bus(1'b0, UFC_A_MSR, 0, d);
    chk("msr_act", d, 32'h32);
    $display("test flow done");
    conclude();
  end
endmodule : tb

// ### ufc_pkg.sv
// Constants, register map, field positions and state types of the UART.
// Assumes one core clock and word-wide AHB-Lite access to the registers.
package ufc_pkg;
  localparam int UFC_DEPTH = 8;
  localparam int UFC_PW = 3;
  localparam int UFC_CW = 4;
  localparam int UFC_TW = 10;
  localparam int UFC_OVS = 16;
  localparam int UFC_TOUT_CHARS = 4;
  localparam int UFC_WL_BASE = 5;
  localparam int UFC_FRAME_FIXED = 2;
  localparam int UFC_HT_BIT = 1;
  localparam logic [3:0] UFC_TK_LAST = 4'(UFC_OVS - 1);
  localparam logic [3:0] UFC_TK_MID = 4'(UFC_OVS / 2 - 1);
  localparam logic [3:0] UFC_WMAX = 4'h8;
  // Prescale: reference clock is twice the core clock over the divisor
  localparam logic [7:0] UFC_PRE_STEP = 8'h02;
  localparam logic [6:0] UFC_DIV_MIN = 7'h02;
  // Register byte offsets
  localparam logic [7:0] UFC_A_DATA = 8'h00, UFC_A_FCR = 8'h04, UFC_A_LCR = 8'h08, UFC_A_MCR = 8'h0C;
  localparam logic [7:0] UFC_A_LSR = 8'h10, UFC_A_MSR = 8'h14, UFC_A_IIR = 8'h18, UFC_A_RFC = 8'h1C;
  localparam logic [7:0] UFC_A_TFC = 8'h20, UFC_A_DL = 8'h24, UFC_A_DIV = 8'h28;
  // Field positions
  localparam int UFC_FCR_EN = 0, UFC_FCR_RXCLR = 1, UFC_FCR_TXCLR = 2, UFC_FCR_TRG = 6;
  localparam int UFC_LCR_WLS = 0, UFC_LCR_STB = 2, UFC_LCR_PEN = 3, UFC_LCR_PMS = 4;
  localparam int UFC_MCR_DTR = 0, UFC_MCR_RTS = 1, UFC_MCR_AFE = 5;
  localparam int UFC_LSR_DR = 0, UFC_LSR_OE = 1, UFC_LSR_PE = 2, UFC_LSR_FE = 3;
  localparam int UFC_LSR_TFE = 5, UFC_LSR_TEMT = 6, UFC_MSR_ACT = 4, UFC_IIR_FIFO = 6;
  localparam int UFC_M_CTS = 0, UFC_M_DSR = 1, UFC_M_RI = 2, UFC_M_DCD = 3;
  // Encodings
  localparam logic [1:0] UFC_PAR_ODD = 2'h0, UFC_PAR_EVEN = 2'h1, UFC_PAR_MARK = 2'h2, UFC_PAR_SPACE = 2'h3;
  localparam logic [3:0] UFC_IIR_NONE = 4'h1, UFC_IIR_THRE = 4'h2, UFC_IIR_RDA = 4'h4;
  localparam logic [3:0] UFC_IIR_TOUT = 4'hC, UFC_IIR_MSI = 4'h0;
  localparam logic [3:0] UFC_TRIG_A = 4'h1, UFC_TRIG_B = 4'h2, UFC_TRIG_C = 4'h4, UFC_TRIG_D = 4'h7;
  // Reset values
  localparam logic [15:0] UFC_DL_RST = 16'h0001;
  localparam logic [6:0] UFC_DIV_RST = 7'h01;

  typedef enum logic [2:0] {UFC_IDLE, UFC_START, UFC_DATA, UFC_PAR, UFC_STOP} ufc_bit_e;
  typedef logic [7:0] ufc_byte_t;

  typedef struct packed {
    logic ph_v, ph_w, rd_wait;
    logic [7:0] ph_a;
    logic [31:0] hrdata;
    logic [7:0] fifo_ctrl_reg, lcr, modem_ctrl_reg;
    logic [15:0] dl, dl_cnt;
    logic [6:0] div;
    logic [7:0] pre_acc;
    logic tick;
    ufc_byte_t [UFC_DEPTH-1:0] txq, rxq;
    logic [UFC_PW-1:0] tx_wp, tx_rp, rx_wp, rx_rp;
    logic [UFC_CW-1:0] tx_cnt, rx_cnt;
    ufc_bit_e tx_st, rx_st;
    ufc_byte_t tx_sh, rx_sh;
    logic [3:0] tx_tk, rx_tk;
    logic [2:0] tx_bit, rx_bit, rx_sy;
    logic tx_par, txd, rx_par, rx_lvl, rx_prv;
    logic [3:0] m_s1, m_s2, m_s3, m_lvl, msr_chg;
    logic thre_ip, oe, pe, fe, rts_blk, rts_n, dtr_n;
    logic [UFC_TW-1:0] tout_cnt;
  } ufc_state_s;
endpackage : ufc_pkg

// ### ufc_remote.sv
// Far-end serial partner: decodes the block's TXD and drives its RXD.
// Assumes one 16x tick per core clock, so each bit lasts 16 cycles.
`timescale 1ns/1ns
module ufc_remote (
  input wire logic clk, // Core clock
  input wire logic txd, // Line from the block
  input wire logic [3:0] nbits, // Data bits per character
  input wire logic par_en, // Parity bit present
  output logic rxd, // Line into the block
  output logic rx_val, // One-cycle strobe per good character
  output logic [8:0] rx_word // Parity bit over data bits
);
  int i;
  initial begin
    rxd = 1'b1;
    rx_val = 1'b0;
    rx_word = '0;
  end
  // Receiver: confirm start at mid bit, then sample bit centres
  always begin
    @(negedge txd);
    repeat (8) @(posedge clk);
    if (txd === 1'b0) begin
      rx_word = '0;
      for (i = 0; i < nbits; i++) begin
        repeat (16) @(posedge clk);
        rx_word[i] = txd;
      end
      if (par_en) begin
        repeat (16) @(posedge clk);
        rx_word[8] = txd;
      end
      repeat (16) @(posedge clk);
      // A low stop is a broken frame, so no strobe
      rx_val <= (txd === 1'b1);
      @(posedge clk);
      rx_val <= 1'b0;
    end
  end
  // Sender: 8N1 characters, LSB first, line idles high
  task automatic send(input logic [7:0] b);
    int k;
    @(posedge clk);
    rxd <= 1'b0;
    repeat (16) @(posedge clk);
    for (k = 0; k < 8; k++) begin
      rxd <= b[k];
      repeat (16) @(posedge clk);
    end
    rxd <= 1'b1;
    repeat (16) @(posedge clk);
  endtask : send
endmodule : ufc_remote

// ### ufc_uart.sv
// UART with 8-byte FIFOs, baud divider and automatic CTS/RTS flow control.
// Assumes a sole AHB-Lite master with HREADY looped from HREADYOUT.
// Contract
// - Data and handshake outputs idle high.
// - Frame: low start, 5-8 data, optional parity, one or two high stops.
// - Separate 8-byte transmit and receive FIFOs; simplex to full duplex.
// - Transmit rate within 0.5 percent; receiver tolerates 2 percent error.
// - Bit rate is twice core clock over prescale, 16 and baud divisor.
// - Transmit-empty event on FIFO empty; cleared by ident read or data write.
// - Single byte moves promptly to shift register; empty event repeats.
// - All-idle flag only after FIFO empty and last bit sent.
// - Transmit FIFO empty flag readable for polling.
// - Transmit level register shows bytes still waiting.
// - Receive-available asserted while level at or above trigger.
// - Timeout after 4 idle character times with data; cleared by reception or read.
// - Data-present flag mirrors a non-empty receive FIFO.
// - Receive level register shows bytes waiting.
// - Flow enable gates CTS; auto RTS needs flow enable and RTS bit.
// - With auto CTS, each character starts only while CTS active.
// - CTS changes raise no modem event while flow control enabled.
// - Auto RTS drops at trigger level or full FIFO.
// - Auto RTS returns once the receive FIFO is empty.
// - Modem lines usable as software controlled I/O.
// - Parity mode: odd, even, mark, space.
// - Word length field selects 5, 6, 7 or 8 bits.
// - Modem inputs active low.
`timescale 1ns/1ns
module ufc_uart import ufc_pkg::*; (
  input wire logic CORE_CLK, // Core clock, 250 MHz
  input wire logic RST_N, // Asynchronous reset
  input wire logic HSEL, // Slave select
  input wire logic [31:0] HADDR, // Byte address
  input wire logic [1:0] HTRANS, // Transfer type
  input wire logic HWRITE, // Write not read
  input wire logic [2:0] HSIZE, // Word only
  input wire logic [31:0] HWDATA, // Write data
  input wire logic HREADY, // Bus ready
  output logic [31:0] HRDATA, // Read data
  output logic HREADYOUT, // Slave ready
  output logic HRESP, // Always OKAY
  output logic TXD, // Serial out
  input wire logic RXD, // Serial in
  input wire logic CTS_N, // Clear to send
  input wire logic DSR_N, // Data set ready
  input wire logic RI_N, // Ring indicator
  input wire logic DCD_N, // Carrier detect
  output logic DTR_N, // Terminal ready
  output logic RTS_N // Request to send
);
  ufc_state_s s;
  ufc_state_s n;
  logic [1:0] rst_sy;
  logic rst_n_sync;
  logic afe, auto_rts, cts_act, fen, rd_now, wr_now, acc;
  logic tx_push, tx_go, rx_pop, rx_done, rx_push, rxclr, txclr;
  logic tx_all_idle, rda, tout_ip;
  logic [3:0] cap, trig, nbits;
  logic [2:0] lastb;
  logic [UFC_TW-1:0] tout_lim;
  logic [3:0] iir_code;
  ufc_byte_t rx_byte;

  // Parity bit for a data xor under the selected mode
  function automatic logic par_bit(input logic [1:0] m, input logic x);
    case (m)
      UFC_PAR_ODD: par_bit = ~x;
      UFC_PAR_EVEN: par_bit = x;
      UFC_PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  // Receive trigger level from the FIFO control field
  function automatic logic [3:0] trig_lvl(input logic [1:0] t);
    case (t)
      2'h0: trig_lvl = UFC_TRIG_A;
      2'h1: trig_lvl = UFC_TRIG_B;
      2'h2: trig_lvl = UFC_TRIG_C;
      default: trig_lvl = UFC_TRIG_D;
    endcase
  endfunction : trig_lvl

  // Reset release through two flops
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sy <= 2'h0;
    end else begin
      rst_sy <= {rst_sy[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_sy[1];

  // Mode decode
  assign afe = s.modem_ctrl_reg[UFC_MCR_AFE];
  assign auto_rts = afe && s.modem_ctrl_reg[UFC_MCR_RTS];
  assign cts_act = !s.m_lvl[UFC_M_CTS];
  assign fen = s.fifo_ctrl_reg[UFC_FCR_EN];
  // With FIFO off the holding path is one byte deep
  assign cap = fen ? UFC_CW'(UFC_DEPTH) : UFC_CW'(1);
  assign trig = fen ? trig_lvl(s.fifo_ctrl_reg[UFC_FCR_TRG+:2]) : UFC_CW'(1);
  assign nbits = 4'(UFC_WL_BASE) + {2'h0, s.lcr[UFC_LCR_WLS+:2]};
  assign lastb = 3'(UFC_WL_BASE - 1) + {1'b0, s.lcr[UFC_LCR_WLS+:2]};
  // Four character times of the current frame, in 16x ticks
  assign tout_lim = UFC_TW'((int'(nbits) + UFC_FRAME_FIXED + int'(s.lcr[UFC_LCR_PEN])
                    + int'(s.lcr[UFC_LCR_STB])) * UFC_OVS * UFC_TOUT_CHARS);

  // Bus phase decode; reads take one wait state so writes land first
  assign acc = HSEL && HTRANS[UFC_HT_BIT] && HREADY;
  assign rd_now = s.ph_v && !s.ph_w && !s.rd_wait;
  assign wr_now = s.ph_v && s.ph_w;
  assign HREADYOUT = !rd_now;
  assign HRESP = 1'b0;
  assign HRDATA = s.hrdata;
  assign TXD = s.txd;
  assign RTS_N = s.rts_n;
  assign DTR_N = s.dtr_n;

  // FIFO events
  assign tx_push = wr_now && s.ph_a == UFC_A_DATA && s.tx_cnt < cap;
  assign rx_pop = rd_now && s.ph_a == UFC_A_DATA && s.rx_cnt != 4'h0;
  assign rxclr = wr_now && s.ph_a == UFC_A_FCR && HWDATA[UFC_FCR_RXCLR];
  assign txclr = wr_now && s.ph_a == UFC_A_FCR && HWDATA[UFC_FCR_TXCLR];
  assign tx_go = s.tick && s.tx_st == UFC_IDLE && s.tx_cnt != 4'h0 && (!afe || cts_act);
  assign rx_done = s.tick && s.rx_st == UFC_STOP && s.rx_tk == UFC_TK_LAST;
  assign rx_push = rx_done && s.rx_cnt < cap;
  assign rx_byte = s.rx_sh >> (UFC_WMAX - nbits);

  // Status terms
  assign tx_all_idle = s.tx_cnt == 4'h0 && s.tx_st == UFC_IDLE;
  assign rda = s.rx_cnt >= trig;
  assign tout_ip = s.rx_cnt != 4'h0 && s.tout_cnt >= tout_lim;

  // Interrupt identity by priority
  always_comb begin
    if (rda) begin
      iir_code = UFC_IIR_RDA;
    end else if (tout_ip) begin
      iir_code = UFC_IIR_TOUT;
    end else if (s.thre_ip) begin
      iir_code = UFC_IIR_THRE;
    end else if (|s.msr_chg) begin
      iir_code = UFC_IIR_MSI;
    end else begin
      iir_code = UFC_IIR_NONE;
    end
  end

  // Next state of the whole block
  always_comb begin
    n = s;
    n.tick = 1'b0;
    // Bus phase tracking
    if (s.ph_v && (s.ph_w || s.rd_wait)) begin
      n.ph_v = 1'b0;
      n.rd_wait = 1'b0;
    end
    if (rd_now) begin
      n.rd_wait = 1'b1;
    end
    if (acc) begin
      n.ph_v = 1'b1;
      n.ph_w = HWRITE;
      n.ph_a = HADDR[7:0];
    end
    // Register writes
    if (wr_now) begin
      case (s.ph_a)
        UFC_A_DATA: n.thre_ip = 1'b0;
        UFC_A_FCR: begin
          n.fifo_ctrl_reg = HWDATA[7:0];
          n.fifo_ctrl_reg[UFC_FCR_RXCLR] = 1'b0;
          n.fifo_ctrl_reg[UFC_FCR_TXCLR] = 1'b0;
        end
        UFC_A_LCR: n.lcr = HWDATA[7:0];
        UFC_A_MCR: n.modem_ctrl_reg = HWDATA[7:0];
        UFC_A_DL: n.dl = HWDATA[15:0];
        UFC_A_DIV: n.div = HWDATA[6:0];
        default: n.fifo_ctrl_reg = s.fifo_ctrl_reg;
      endcase
    end
    // Register reads and their side effects
    if (rd_now) begin
      n.hrdata = 32'h0;
      case (s.ph_a)
        UFC_A_DATA: n.hrdata[7:0] = (s.rx_cnt != 4'h0) ? s.rxq[s.rx_rp] : 8'h00;
        UFC_A_FCR: n.hrdata[7:0] = s.fifo_ctrl_reg;
        UFC_A_LCR: n.hrdata[7:0] = s.lcr;
        UFC_A_MCR: n.hrdata[7:0] = s.modem_ctrl_reg;
        UFC_A_LSR: begin
          n.hrdata[UFC_LSR_DR] = s.rx_cnt != 4'h0;
          n.hrdata[UFC_LSR_OE] = s.oe;
          n.hrdata[UFC_LSR_PE] = s.pe;
          n.hrdata[UFC_LSR_FE] = s.fe;
          n.hrdata[UFC_LSR_TFE] = s.tx_cnt == 4'h0;
          n.hrdata[UFC_LSR_TEMT] = tx_all_idle;
          n.oe = 1'b0;
          n.pe = 1'b0;
          n.fe = 1'b0;
        end
        UFC_A_MSR: begin
          n.hrdata[7:0] = {~s.m_lvl, s.msr_chg};
          n.msr_chg = 4'h0;
        end
        UFC_A_IIR: begin
          n.hrdata[UFC_IIR_FIFO+:2] = {2{fen}};
          n.hrdata[3:0] = iir_code;
          if (iir_code == UFC_IIR_THRE) begin
            n.thre_ip = 1'b0;
          end
        end
        UFC_A_RFC: n.hrdata[UFC_CW-1:0] = s.rx_cnt;
        UFC_A_TFC: n.hrdata[UFC_CW-1:0] = s.tx_cnt;
        UFC_A_DL: n.hrdata[15:0] = s.dl;
        UFC_A_DIV: n.hrdata[6:0] = s.div;
        default: n.hrdata = 32'h0;
      endcase
    end
    // Reference clock: adds two per core cycle, so the average rate is exact
    n.pre_acc = s.pre_acc + UFC_PRE_STEP;
    if (n.pre_acc >= {1'b0, (s.div < UFC_DIV_MIN) ? UFC_DIV_MIN : s.div}) begin
      n.pre_acc = n.pre_acc - {1'b0, (s.div < UFC_DIV_MIN) ? UFC_DIV_MIN : s.div};
      if (s.dl_cnt + 16'h0001 >= s.dl) begin
        n.dl_cnt = 16'h0000;
        n.tick = 1'b1;
      end else begin
        n.dl_cnt = s.dl_cnt + 16'h0001;
      end
    end
    // Transmit FIFO
    if (tx_push) begin
      n.txq[s.tx_wp] = HWDATA[7:0];
      n.tx_wp = s.tx_wp + 1'b1;
    end
    if (tx_go) begin
      n.tx_rp = s.tx_rp + 1'b1;
    end
    n.tx_cnt = s.tx_cnt + UFC_CW'(tx_push) - UFC_CW'(tx_go);
    if (txclr) begin
      n.tx_wp = '0;
      n.tx_rp = '0;
      n.tx_cnt = '0;
    end
    // Transmit shifter, one step per 16x tick
    if (s.tick) begin
      n.tx_tk = s.tx_tk + 4'h1;
      case (s.tx_st)
        UFC_IDLE: begin
          n.txd = 1'b1;
          if (tx_go) begin
            n.tx_sh = s.txq[s.tx_rp];
            n.tx_st = UFC_START;
            n.tx_tk = 4'h0;
            n.tx_par = 1'b0;
            n.txd = 1'b0;
          end
        end
        UFC_START: if (s.tx_tk == UFC_TK_LAST) begin
          n.tx_st = UFC_DATA;
          n.tx_bit = 3'h0;
          n.txd = s.tx_sh[0];
        end
        UFC_DATA: if (s.tx_tk == UFC_TK_LAST) begin
          n.tx_par = s.tx_par ^ s.tx_sh[0];
          n.tx_sh = s.tx_sh >> 1;
          if (s.tx_bit == lastb) begin
            n.tx_bit = 3'h0;
            if (s.lcr[UFC_LCR_PEN]) begin
              n.tx_st = UFC_PAR;
              n.txd = par_bit(s.lcr[UFC_LCR_PMS+:2], s.tx_par ^ s.tx_sh[0]);
            end else begin
              n.tx_st = UFC_STOP;
              n.txd = 1'b1;
            end
          end else begin
            n.tx_bit = s.tx_bit + 3'h1;
            n.txd = s.tx_sh[1];
          end
        end
        UFC_PAR: if (s.tx_tk == UFC_TK_LAST) begin
          n.tx_st = UFC_STOP;
          n.txd = 1'b1;
        end
        UFC_STOP: if (s.tx_tk == UFC_TK_LAST) begin
          // CTS is looked at again only when the line returns to idle
          if (s.lcr[UFC_LCR_STB] && s.tx_bit == 3'h0) begin
            n.tx_bit = 3'h1;
          end else begin
            n.tx_st = UFC_IDLE;
          end
        end
        default: n.tx_st = UFC_IDLE;
      endcase
    end
    // Line and modem synchronisers, stable once stages two and three agree
    n.rx_sy = {s.rx_sy[1:0], RXD};
    if (s.rx_sy[1] == s.rx_sy[2]) begin
      n.rx_lvl = s.rx_sy[2];
    end
    n.rx_prv = s.rx_lvl;
    n.m_s1 = {DCD_N, RI_N, DSR_N, CTS_N};
    n.m_s2 = s.m_s1;
    n.m_s3 = s.m_s2;
    for (int i = 0; i < 4; i++) begin
      if (s.m_s2[i] == s.m_s3[i] && s.m_s3[i] != s.m_lvl[i]) begin
        n.m_lvl[i] = s.m_s3[i];
        if (!(i == UFC_M_CTS && afe)) begin
          n.msr_chg[i] = 1'b1;
        end
      end
    end
    // Receiver: falling edge starts, mid-bit sampling afterwards
    if (s.rx_st == UFC_IDLE && s.rx_prv && !s.rx_lvl) begin
      n.rx_st = UFC_START;
      n.rx_tk = 4'h0;
    end else if (s.tick) begin
      n.rx_tk = s.rx_tk + 4'h1;
      case (s.rx_st)
        UFC_START: if (s.rx_tk == UFC_TK_MID) begin
          // A glitch shorter than half a bit is dropped here
          n.rx_st = s.rx_lvl ? UFC_IDLE : UFC_DATA;
          n.rx_tk = 4'h0;
          n.rx_bit = 3'h0;
          n.rx_par = 1'b0;
        end
        UFC_DATA: if (s.rx_tk == UFC_TK_LAST) begin
          n.rx_sh = {s.rx_lvl, s.rx_sh[7:1]};
          n.rx_par = s.rx_par ^ s.rx_lvl;
          if (s.rx_bit == lastb) begin
            n.rx_st = s.lcr[UFC_LCR_PEN] ? UFC_PAR : UFC_STOP;
          end else begin
            n.rx_bit = s.rx_bit + 3'h1;
          end
        end
        UFC_PAR: if (s.rx_tk == UFC_TK_LAST) begin
          n.rx_st = UFC_STOP;
          if (s.rx_lvl != par_bit(s.lcr[UFC_LCR_PMS+:2], s.rx_par)) begin
            n.pe = 1'b1;
          end
        end
        UFC_STOP: if (s.rx_tk == UFC_TK_LAST) begin
          n.rx_st = UFC_IDLE;
          if (!s.rx_lvl) begin
            n.fe = 1'b1;
          end
          if (!rx_push) begin
            n.oe = 1'b1;
          end
        end
        default: n.rx_st = UFC_IDLE;
      endcase
    end
    // Receive FIFO
    if (rx_push) begin
      n.rxq[s.rx_wp] = rx_byte;
      n.rx_wp = s.rx_wp + 1'b1;
    end
    if (rx_pop) begin
      n.rx_rp = s.rx_rp + 1'b1;
    end
    n.rx_cnt = s.rx_cnt + UFC_CW'(rx_push) - UFC_CW'(rx_pop);
    if (rxclr) begin
      n.rx_wp = '0;
      n.rx_rp = '0;
      n.rx_cnt = '0;
    end
    // Timeout counter, saturating at the limit
    if (rx_push || rx_pop || s.rx_cnt == 4'h0) begin
      n.tout_cnt = '0;
    end else if (s.tick && s.tout_cnt < tout_lim) begin
      n.tout_cnt = s.tout_cnt + 1'b1;
    end
    // Set after clear, so an emptying in the clearing cycle survives
    if (s.tx_cnt != 4'h0 && n.tx_cnt == 4'h0) begin
      n.thre_ip = 1'b1;
    end
    // Auto RTS hysteresis: drop at trigger, return only when empty
    if (s.rx_cnt == 4'h0) begin
      n.rts_blk = 1'b0;
    end else if (rda || s.rx_cnt == cap) begin
      n.rts_blk = 1'b1;
    end
    n.rts_n = !(s.modem_ctrl_reg[UFC_MCR_RTS] && !(afe && n.rts_blk));
    n.dtr_n = !s.modem_ctrl_reg[UFC_MCR_DTR];
  end

  // State register; idle lines high from reset
  always_ff @(posedge CORE_CLK or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s <= '0;
      s.txd <= 1'b1;
      s.rts_n <= 1'b1;
      s.dtr_n <= 1'b1;
      s.rx_sy <= '1;
      s.rx_lvl <= 1'b1;
      s.rx_prv <= 1'b1;
      s.m_s1 <= '1;
      s.m_s2 <= '1;
      s.m_s3 <= '1;
      s.m_lvl <= '1;
      s.dl <= UFC_DL_RST;
      s.div <= UFC_DIV_RST;
    end else begin
      s <= n;
    end
  end

  // Checks
  default clocking ufc_cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!rst_n_sync);

  sequence s_tx_begin;
    s.tx_st == UFC_IDLE ##1 s.tx_st == UFC_START;
  endsequence
  sequence s_fill_to_trig;
    rx_push && !rx_pop && !wr_now && s.rx_cnt == trig - 4'h1;
  endsequence

  a_idle_line_high: assert property (s.tx_st == UFC_IDLE |-> TXD)
    else $error("transmit line low while idle");
  a_start_bit_low: assert property (s_tx_begin |-> !TXD)
    else $error("start bit not low");
  a_fifo_bounds: assert property (s.tx_cnt <= cap && s.rx_cnt <= UFC_CW'(UFC_DEPTH))
    else $error("FIFO count beyond capacity");
  a_thre_on_empty: assert property ($past(s.tx_cnt) != 4'h0 && s.tx_cnt == 4'h0 |-> s.thre_ip)
    else $error("empty event missing");
  a_busy_not_idle: assert property (s.tx_st != UFC_IDLE |-> !tx_all_idle)
    else $error("all-idle while shifting");
  a_rda_at_trig: assert property (s_fill_to_trig |=> rda)
    else $error("receive-available late");
  a_tout_restart: assert property (rx_push || rx_pop |=> !tout_ip)
    else $error("timeout not cleared");
  a_dr_readback: assert property (rd_now && s.ph_a == UFC_A_LSR |=>
    s.hrdata[UFC_LSR_DR] == ($past(s.rx_cnt) != 4'h0) && HREADYOUT)
    else $error("data-present flag wrong");
  a_cts_holds_tx: assert property (s.tx_st == UFC_IDLE && afe && !cts_act |=> s.tx_st == UFC_IDLE)
    else $error("character started without CTS");
  a_cts_no_event: assert property (afe && !s.msr_chg[UFC_M_CTS] |=> !s.msr_chg[UFC_M_CTS])
    else $error("CTS change flagged under flow control");
  a_rts_drops: assert property (auto_rts && rda |=> RTS_N)
    else $error("RTS still active at trigger");
  a_rts_returns: assert property (auto_rts && s.rx_cnt == 4'h0 |=> !RTS_N)
    else $error("RTS not restored when empty");
endmodule : ufc_uart
